//--- hdl/dtm_fsm.sv
// dtm_fsm.sv: timing-mode sequencer of the primary loop with APB registers.
// assumes monitor, selector and loop filter run on clk; APB master on clk.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps

`include "dtm_map.svh"

module dtm_fsm import dtm_pkg::*; #(
   parameter int N_IN = `DTM_N_IN,
   parameter int FW = `DTM_FW,
   parameter int TICK_CYC = `DTM_TICK_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N_IN-1:0] input_valid_flag,
   input wire logic [N_IN-1:0] activity_alarm,
   input wire logic [2:0] selected_ref,
   input wire logic phase_lock,
   input wire logic loss_of_lock,
   input wire logic fast_ref_fail,
   input wire logic [FW-1:0] integral_frequency_value,
   output logic [N_IN-1:0] ref_usable,
   output logic revertive_enable,
   output logic lock_pin,
   output logic [2:0] loop_state_field,
   output logic loop_isolate,
   output logic [1:0] integral_frequency_value_source,
   output logic [FW-1:0] holdover_integral_frequency_value,
   output logic [`DTM_OFS_W-1:0] master_clock_offset
);

   localparam int QUAL = `DTM_QUAL_TICKS;
   localparam int TPS = `DTM_TICKS_PER_SEC;

   // -------------------------------------------------------------------
   // registers and internal state
   // -------------------------------------------------------------------
   dtm_state_t state_q, state_d;
   logic [2:0] force_state_q;
   logic force_en_q, lock_pin_enable_q, freerun_holdover_select_q;
   logic holdover_averaging_select_q;
   logic [15:0] lock_timeout_q;
   logic state_chg_q, holdover_ready_flag_q, holdover_ready_flag_lat_q;
   logic [N_IN-1:0] lock_alm_q, eff_valid;
   logic [31:0] tick_cnt_q;
   logic tick_q;
   logic [7:0] lock_cnt_q, inv_cnt_q;
   logic [4:0] sec_div_q;
   logic [15:0] to_sec_q;
   logic [2:0] sel_prev_q;
   logic [FW-1:0] hist0_q, hist1_q, avg_q;
   logic [FW+4:0] sum_q;
   logic [4:0] avg_cnt_q;
   logic wr_en, acc;
   logic ref_bad, any_valid, oth_valid, lock_done, inv_done, to_done;
   logic reenter, alarm_set, sel_chg, restart;
   logic [N_IN-1:0] sel_oh, alm_clr;
   logic [FW-1:0] stored_val;
   logic [FW+16:0] avg_prod;
   dtm_src_t src_d;

   // -------------------------------------------------------------------
   // apb slave: one wait cycle, answer registered
   // -------------------------------------------------------------------
   assign acc = psel & penable;
   assign wr_en = acc & pready & pwrite;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= acc & ~pready;
         if (acc & ~pready) begin
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (paddr == `DTM_MCFG1_ADDR) begin
               prdata[`DTM_MC1_FSTATE_LSB +: 3] <= force_state_q;
               prdata[`DTM_MC1_FORCE_BIT] <= force_en_q;
               prdata[`DTM_MC1_LOCK_PIN_ENABLE_BIT] <= lock_pin_enable_q;
            end else if (paddr == `DTM_MCFG3_ADDR) begin
               prdata[`DTM_MC3_REVERTIVE_ENABLE_BIT] <= revertive_enable;
               prdata[`DTM_MC3_FREERUN_HOLDOVER_SELECT_BIT] <= freerun_holdover_select_q;
            end else if (paddr == `DTM_HCFG3_ADDR) begin
               prdata[`DTM_HC3_AVG_BIT] <= holdover_averaging_select_q;
            end else if (paddr == `DTM_LOCKTO_ADDR) begin
               prdata[15:0] <= lock_timeout_q;
            end else if (paddr == `DTM_OPERATING_STATE_REG_ADDR) begin
               prdata[2:0] <= state_q;
            end else if (paddr == `DTM_LSTAT2_ADDR) begin
               prdata[`DTM_LS2_STATE_BIT] <= state_chg_q;
            end else if (paddr == `DTM_LSTAT4_ADDR) begin
               prdata[`DTM_LS4_HOLDOVER_READY_FLAG_BIT] <= holdover_ready_flag_lat_q;
            end else if (paddr == `DTM_VALID_ADDR) begin
               prdata[N_IN-1:0] <= eff_valid;
               prdata[`DTM_VAL_HOLDOVER_READY_FLAG_BIT] <= holdover_ready_flag_q;
            end else if (paddr == `DTM_ALARM_ADDR) begin
               prdata[N_IN-1:0] <= activity_alarm;
               prdata[`DTM_ALM_LOCK_LSB +: N_IN] <= lock_alm_q;
            end else if (paddr == `DTM_MCLKOFS_ADDR) begin
               prdata[`DTM_OFS_W-1:0] <= master_clock_offset;
            end else if (paddr == `DTM_HOFREQ_ADDR) begin
               prdata[FW-1:0] <= holdover_integral_frequency_value;
            end else begin
               pslverr <= 1'b1;
            end
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         force_state_q <= 3'h0;
         force_en_q <= 1'b0;
         lock_pin_enable_q <= 1'b0;
         revertive_enable <= 1'b0;
         freerun_holdover_select_q <= 1'b0;
         holdover_averaging_select_q <= 1'b0;
         lock_timeout_q <= `DTM_LOCKTO_RST;
         master_clock_offset <= `DTM_MCLKOFS_RST;
      end else if (wr_en) begin
         if (paddr == `DTM_MCFG1_ADDR) begin
            force_state_q <= pwdata[`DTM_MC1_FSTATE_LSB +: 3];
            force_en_q <= pwdata[`DTM_MC1_FORCE_BIT];
            lock_pin_enable_q <= pwdata[`DTM_MC1_LOCK_PIN_ENABLE_BIT];
         end else if (paddr == `DTM_MCFG3_ADDR) begin
            revertive_enable <= pwdata[`DTM_MC3_REVERTIVE_ENABLE_BIT];
            freerun_holdover_select_q <= pwdata[`DTM_MC3_FREERUN_HOLDOVER_SELECT_BIT];
         end else if (paddr == `DTM_HCFG3_ADDR) begin
            holdover_averaging_select_q <= pwdata[`DTM_HC3_AVG_BIT];
         end else if (paddr == `DTM_LOCKTO_ADDR) begin
            lock_timeout_q <= pwdata[15:0];
         end else if (paddr == `DTM_MCLKOFS_ADDR) begin
            master_clock_offset <= pwdata[`DTM_OFS_W-1:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // 50 ms tick from the master clock
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // input validity and per-input lock alarms
   // -------------------------------------------------------------------
   generate
      for (genvar i = 0; i < N_IN; i++) begin : g_in
         assign sel_oh[i] = (selected_ref == 3'(i));
         assign alm_clr[i] = wr_en & (paddr == `DTM_ALARM_ADDR) &
                             pwdata[`DTM_ALM_LOCK_LSB + i];
         assign eff_valid[i] = input_valid_flag[i] & ~activity_alarm[i] & ~lock_alm_q[i];
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               lock_alm_q[i] <= 1'b0;
            end else if (alarm_set & sel_oh[i]) begin
               lock_alm_q[i] <= 1'b1;
            end else if (alm_clr[i]) begin
               lock_alm_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_usable <= '0;
      end else begin
         ref_usable <= eff_valid;
      end
   end

   assign any_valid = |eff_valid;
   assign ref_bad = ~|(eff_valid & sel_oh);
   assign oth_valid = |(eff_valid & ~sel_oh);
   assign lock_done = (lock_cnt_q >= 8'(QUAL));
   assign inv_done = (inv_cnt_q >= 8'(QUAL));
   assign to_done = tick_q & (sec_div_q == 5'(TPS - 1)) &
                    (to_sec_q + 16'h1 == lock_timeout_q);
   assign sel_chg = (selected_ref != sel_prev_q);

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      reenter = 1'b0;
      alarm_set = 1'b0;
      case (state_q)
         DTM_FREERUN: begin
            if (any_valid) begin
               state_d = DTM_PRELOCK;
            end
         end
         DTM_PRELOCK, DTM_PRELOCK2: begin
            if (lock_done) begin
               state_d = DTM_LOCKED;
            end else if (inv_done) begin
               state_d = (state_q == DTM_PRELOCK) ? DTM_FREERUN : DTM_HOLDOVER;
            end else if (to_done) begin
               alarm_set = 1'b1;
               reenter = 1'b1;
            end else if (sel_chg & revertive_enable & any_valid) begin
               reenter = 1'b1;
            end
         end
         DTM_LOCKED: begin
            if (loss_of_lock) begin
               state_d = DTM_LOSSLOCK;
            end else if (ref_bad & oth_valid) begin
               state_d = DTM_PRELOCK2;
            end else if (ref_bad & inv_done) begin
               state_d = DTM_HOLDOVER;
            end
         end
         DTM_LOSSLOCK: begin
            if (lock_done) begin
               state_d = DTM_LOCKED;
            end else if (to_done) begin
               alarm_set = 1'b1;
               if (oth_valid) begin
                  state_d = DTM_PRELOCK2;
               end
            end else if (ref_bad & inv_done) begin
               state_d = oth_valid ? DTM_PRELOCK2 : DTM_HOLDOVER;
            end
         end
         DTM_HOLDOVER: begin
            if (any_valid) begin
               state_d = DTM_PRELOCK2;
            end
         end
         default: begin
            state_d = DTM_FREERUN;
         end
      endcase
      if (force_en_q & (force_state_q <= 3'h5)) begin
         state_d = dtm_state_t'(force_state_q);
         reenter = 1'b0;
      end
   end

   assign restart = (state_d != state_q) | reenter;

   // -------------------------------------------------------------------
   // state register, change flag, lock pin
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= DTM_FREERUN;
         sel_prev_q <= 3'h0;
         loop_state_field <= 3'h0;
         lock_pin <= 1'b0;
      end else begin
         state_q <= state_d;
         sel_prev_q <= selected_ref;
         loop_state_field <= state_d;
         lock_pin <= lock_pin_enable_q & (state_d == DTM_LOCKED);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_chg_q <= 1'b0;
      end else if (restart) begin
         state_chg_q <= 1'b1;
      end else if (wr_en & (paddr == `DTM_LSTAT2_ADDR) & pwdata[`DTM_LS2_STATE_BIT]) begin
         state_chg_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // qualification, invalidity and timeout counters
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_cnt_q <= 8'h0;
         inv_cnt_q <= 8'h0;
         sec_div_q <= 5'h0;
         to_sec_q <= 16'h0;
      end else if (restart) begin
         lock_cnt_q <= 8'h0;
         inv_cnt_q <= 8'h0;
         sec_div_q <= 5'h0;
         to_sec_q <= 16'h0;
      end else if (tick_q) begin
         if (!phase_lock | ref_bad) begin
            lock_cnt_q <= 8'h0;
         end else if (!lock_done) begin
            lock_cnt_q <= lock_cnt_q + 8'h1;
         end
         if (((state_q == DTM_PRELOCK) | (state_q == DTM_PRELOCK2)) ? any_valid : !ref_bad) begin
            inv_cnt_q <= 8'h0;
         end else if (!inv_done) begin
            inv_cnt_q <= inv_cnt_q + 8'h1;
         end
         if (sec_div_q == 5'(TPS - 1)) begin
            sec_div_q <= 5'h0;
            to_sec_q <= to_sec_q + 16'h1;
         end else begin
            sec_div_q <= sec_div_q + 5'h1;
         end
      end
   end

   // -------------------------------------------------------------------
   // frequency history and one-second average
   // -------------------------------------------------------------------
   assign avg_prod = (FW+17)'(sum_q + (FW+5)'(integral_frequency_value)) *
                     (FW+17)'(`DTM_AVG_RECIP);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hist0_q <= '0;
         hist1_q <= '0;
      end else if (tick_q) begin
         hist0_q <= integral_frequency_value;
         hist1_q <= hist0_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sum_q <= '0;
         avg_cnt_q <= 5'h0;
         avg_q <= '0;
         holdover_ready_flag_q <= 1'b0;
      end else if (state_q != DTM_LOCKED) begin
         sum_q <= '0;
         avg_cnt_q <= 5'h0;
         if (state_q == DTM_FREERUN) begin
            holdover_ready_flag_q <= 1'b0;
         end
      end else if (tick_q) begin
         if (avg_cnt_q == 5'(TPS - 1)) begin
            avg_q <= avg_prod[FW+15:16];
            holdover_ready_flag_q <= 1'b1;
            sum_q <= '0;
            avg_cnt_q <= 5'h0;
         end else begin
            sum_q <= sum_q + (FW+5)'(integral_frequency_value);
            avg_cnt_q <= avg_cnt_q + 5'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         holdover_ready_flag_lat_q <= 1'b0;
      end else if (holdover_ready_flag_q) begin
         holdover_ready_flag_lat_q <= 1'b1;
      end else if (wr_en & (paddr == `DTM_LSTAT4_ADDR) & pwdata[`DTM_LS4_HOLDOVER_READY_FLAG_BIT]) begin
         holdover_ready_flag_lat_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // frequency source: track, oscillator plus offset, stored value
   // -------------------------------------------------------------------
   assign stored_val = (holdover_averaging_select_q & holdover_ready_flag_q) ? avg_q : hist1_q;

   always_comb begin
      src_d = DTM_SRC_TRACK;
      if (state_d == DTM_FREERUN) begin
         src_d = DTM_SRC_OSC;
      end else if ((state_d == DTM_HOLDOVER) | fast_ref_fail) begin
         src_d = freerun_holdover_select_q ? DTM_SRC_OSC : DTM_SRC_STORED;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         integral_frequency_value_source <= DTM_SRC_OSC;
         holdover_integral_frequency_value <= '0;
         loop_isolate <= 1'b0;
      end else begin
         integral_frequency_value_source <= src_d;
         loop_isolate <= fast_ref_fail & (state_d != DTM_FREERUN) &
                         (state_d != DTM_HOLDOVER);
         if ((src_d == DTM_SRC_STORED) & (integral_frequency_value_source != DTM_SRC_STORED)) begin
            holdover_integral_frequency_value <= stored_val;
         end
      end
   end

endmodule

//--- hdl/dtm_map.svh
// dtm_map.svh: offsets, field positions, reset values and timing counts
// for the primary loop timing-mode sequencer; included by its bare name.
`ifndef DTM_MAP_SVH
`define DTM_MAP_SVH

// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define DTM_CLK_HZ 40000000
`define DTM_TICK_MS 50
`define DTM_TICK_CYC (`DTM_CLK_HZ / 1000 * `DTM_TICK_MS)
`define DTM_TICKS_PER_SEC (1000 / `DTM_TICK_MS)
`define DTM_QUAL_SEC 2
`define DTM_QUAL_TICKS (`DTM_QUAL_SEC * `DTM_TICKS_PER_SEC)
`define DTM_AVG_RECIP ((65536 + `DTM_TICKS_PER_SEC / 2) / `DTM_TICKS_PER_SEC)

// -------------------------------------------------------------------
// sizes
// -------------------------------------------------------------------
`define DTM_N_IN 5
`define DTM_FW 24
`define DTM_OFS_W 24

// -------------------------------------------------------------------
// register offsets (byte addresses)
// -------------------------------------------------------------------
`define DTM_MCFG1_ADDR 8'h00
`define DTM_MCFG3_ADDR 8'h04
`define DTM_HCFG3_ADDR 8'h08
`define DTM_LOCKTO_ADDR 8'h0c
`define DTM_OPERATING_STATE_REG_ADDR 8'h10
`define DTM_LSTAT2_ADDR 8'h14
`define DTM_LSTAT4_ADDR 8'h18
`define DTM_VALID_ADDR 8'h1c
`define DTM_ALARM_ADDR 8'h20
`define DTM_MCLKOFS_ADDR 8'h24
`define DTM_HOFREQ_ADDR 8'h28

// -------------------------------------------------------------------
// fields and reset values
// -------------------------------------------------------------------
`define DTM_MC1_FSTATE_LSB 0
`define DTM_MC1_FORCE_BIT 3
`define DTM_MC1_LOCK_PIN_ENABLE_BIT 4
`define DTM_MC3_REVERTIVE_ENABLE_BIT 0
`define DTM_MC3_FREERUN_HOLDOVER_SELECT_BIT 1
`define DTM_HC3_AVG_BIT 0
`define DTM_LS2_STATE_BIT 0
`define DTM_LS4_HOLDOVER_READY_FLAG_BIT 0
`define DTM_VAL_HOLDOVER_READY_FLAG_BIT 16
`define DTM_ALM_LOCK_LSB 8
`define DTM_LOCKTO_RST 16'h0064
`define DTM_MCLKOFS_RST 24'h000000

`endif

//--- hdl/dtm_pkg.sv
// dtm_pkg.sv: types of the primary loop timing-mode sequencer.
// assumes nothing beyond a SystemVerilog compiler.
package dtm_pkg;

   typedef enum logic [2:0] {
      DTM_FREERUN,
      DTM_PRELOCK,
      DTM_PRELOCK2,
      DTM_LOCKED,
      DTM_LOSSLOCK,
      DTM_HOLDOVER
   } dtm_state_t;

   typedef enum logic [1:0] {
      DTM_SRC_TRACK,
      DTM_SRC_OSC,
      DTM_SRC_STORED
   } dtm_src_t;

endpackage

//--- verif/dtm_fsm_monitor.sv
// dtm_fsm_monitor.sv: port checker for the primary loop sequencer.
// assumes it is bound into dtm_fsm, one clock clk, reset rstn.
`timescale 1ns/1ps

module dtm_fsm_monitor #(
   parameter int N_IN = 5,
   parameter int TICK_CYC = 20
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [N_IN-1:0] ref_usable,
   input wire logic phase_lock,
   input wire logic loss_of_lock,
   input wire logic fast_ref_fail,
   input wire logic lock_pin,
   input wire logic [2:0] loop_state_field,
   input wire logic loop_isolate,
   input wire logic [1:0] integral_frequency_value_source
);
   // ---------------------------------------------
   // cycles of unbroken phase lock
   // ---------------------------------------------
   int lock_run_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_run_q <= 0;
      end else begin
         lock_run_q <= phase_lock ? lock_run_q + 1 : 0;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   a_state_code: assert property (loop_state_field <= 3'h5)
      else $error("state code out of range");
   a_reset_free: assert property ($rose(rstn) |-> loop_state_field == 3'h0)
      else $error("not free-run after reset");
   a_free_osc: assert property (
      loop_state_field == 3'h0 && $past(loop_state_field) == 3'h0 |-> integral_frequency_value_source == 2'h1)
      else $error("free-run not on oscillator");
   a_free_leave: assert property (
      loop_state_field == 3'h0 && |ref_usable |-> ##[1:2] loop_state_field == 3'h1)
      else $error("free-run kept with usable input");
   a_lock_qual: assert property (
      loop_state_field == 3'h3 && $past(loop_state_field) != 3'h3
      |-> lock_run_q >= 39 * TICK_CYC)
      else $error("locked without two seconds of lock");
   a_lock_pin: assert property (
      lock_pin |-> loop_state_field == 3'h3 || $past(loop_state_field) == 3'h3)
      else $error("lock pin high outside locked");
   a_lost_lock: assert property (
      loop_state_field == 3'h3 && loss_of_lock |-> ##[1:2] loop_state_field == 3'h4)
      else $error("loss of lock ignored");
   a_hold_leave: assert property (
      loop_state_field == 3'h5 && |ref_usable |-> ##[1:2] loop_state_field == 3'h2)
      else $error("holdover kept with usable input");
   a_hold_stored: assert property (
      loop_state_field == 3'h5 && $past(loop_state_field) == 3'h5 |-> integral_frequency_value_source != 2'h0)
      else $error("holdover tracking an input");
   a_mini_hold: assert property (
      loop_state_field == 3'h3 && fast_ref_fail |-> ##[1:2] loop_isolate)
      else $error("loop not isolated on fast failure");
endmodule

bind dtm_fsm dtm_fsm_monitor #(.N_IN(N_IN), .TICK_CYC(TICK_CYC)) i_dtm_fsm_monitor (
   .clk, .rstn, .ref_usable, .phase_lock, .loss_of_lock, .fast_ref_fail, .lock_pin,
   .loop_state_field, .loop_isolate, .integral_frequency_value_source);

//--- verif/dtm_ref_model.sv
// dtm_ref_model.sv: stand-in for reference selector and lock detector.
// assumes the sequencer's ref_usable and revertive_enable on clk.
`timescale 1ns/1ps

module dtm_ref_model #(
   parameter int N_IN = 5
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [N_IN-1:0] want_valid,
   input wire logic want_lock,
   input wire logic [N_IN-1:0] ref_usable,
   input wire logic revertive_enable,
   output logic [N_IN-1:0] input_valid_flag,
   output logic [2:0] selected_ref,
   output logic phase_lock
);
   logic [2:0] best;
   // lowest usable index has the highest priority
   always_comb begin
      best = selected_ref;
      for (int i = N_IN - 1; i >= 0; i--) begin
         if (ref_usable[i]) best = 3'(i);
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         input_valid_flag <= '0;
         selected_ref <= 3'h0;
         phase_lock <= 1'b0;
      end else begin
         input_valid_flag <= want_valid;
         if (revertive_enable || !ref_usable[selected_ref]) selected_ref <= best;
         // lock is lost as soon as the reference is unusable
         phase_lock <= want_lock && ref_usable[selected_ref];
      end
   end
endmodule

//--- verif/tb.sv
// tb.sv: self-checking bench for the primary loop sequencer.
// assumes dtm_fsm, dtm_ref_model and the bound checker are compiled first.
`timescale 1ns/1ps

module tb;
   typedef struct {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } dtm_row_t;

   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e, phase_lock, revertive_enable, lock_pin, loop_isolate;
   logic [4:0] want_valid = 5'h0, activity_alarm = 5'h0, input_valid_flag, ref_usable;
   logic want_lock = 1'b0, loss_of_lock = 1'b0, fast_ref_fail = 1'b0;
   logic [23:0] integral_frequency_value = 24'h123456, holdover_integral_frequency_value, master_clock_offset;
   logic [2:0] selected_ref, loop_state_field;
   logic [1:0] integral_frequency_value_source;
   int n, cyc = 0, miscompares = 0, n_checks = 0;
   dtm_row_t rows [11] = '{
      '{0, 8'h0c, 0, 32'h64, 0}, '{0, 8'h10, 0, 0, 0}, '{0, 8'h00, 0, 0, 0},
      '{0, 8'h2c, 0, 0, 1}, '{1, 8'h2c, 5, 0, 1}, '{1, 8'h24, 32'habcdef, 0, 0},
      '{1, 8'h28, 1, 0, 0}, '{0, 8'h28, 0, 0, 0}, '{1, 8'h0c, 3, 0, 0},
      '{1, 8'h00, 32'h10, 0, 0}, '{0, 8'h0c, 0, 3, 0}};

   dtm_ref_model i_dtm_ref_model (.clk, .rstn, .want_valid, .want_lock, .ref_usable,
      .revertive_enable, .input_valid_flag, .selected_ref, .phase_lock);
   dtm_fsm #(.TICK_CYC(20)) i_dtm_fsm (.clk, .rstn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .input_valid_flag, .activity_alarm, .selected_ref,
      .phase_lock, .loss_of_lock, .fast_ref_fail, .integral_frequency_value, .ref_usable,
      .revertive_enable, .lock_pin, .loop_state_field, .loop_isolate, .integral_frequency_value_source,
      .holdover_integral_frequency_value, .master_clock_offset);

   always #12.5 clk = ~clk;

   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic er);
      int k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k == 20) miscompares++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_state(input logic [2:0] s, input int lim);
      n = 0;
      while (loop_state_field !== s && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         miscompares++;
         test_done;
      end
   end

   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, r, e);
         if (!rows[i].w) chk("rdata", rows[i].x, r);
         chk("pslverr", 32'(rows[i].e), 32'(e));
      end
      chk("mclk_ofs", 32'habcdef, 32'(master_clock_offset));
      $display("test registers done");
      want_valid <= 5'h02;
      wait_state(3'h1, 10);
      chk("state", 32'h1, 32'(loop_state_field));
      chk("usable", 32'h2, 32'(ref_usable));
      apb(0, 8'h14, 0, r, e);
      chk("chg_bit", 32'h1, r);
      apb(1, 8'h14, 1, r, e);
      apb(0, 8'h14, 0, r, e);
      chk("chg_clr", 32'h0, r);
      want_lock <= 1'b1;
      wait_state(3'h3, 1000);
      chk("lock_time", 32'h1, 32'(n >= 760 && n <= 840));
      repeat (2) @(posedge clk);
      chk("lock_pin", 32'h1, 32'(lock_pin));
      $display("test lock done");
      loss_of_lock <= 1'b1;
      want_lock <= 1'b0;
      wait_state(3'h4, 5);
      chk("state", 32'h4, 32'(loop_state_field));
      loss_of_lock <= 1'b0;
      want_lock <= 1'b1;
      wait_state(3'h3, 1000);
      chk("relock", 32'h1, 32'(n >= 760 && n <= 840));
      fast_ref_fail <= 1'b1;
      repeat (2) @(posedge clk);
      chk("isolate", 32'h1, 32'(loop_isolate));
      fast_ref_fail <= 1'b0;
      repeat (4) @(posedge clk);
      chk("isolate", 32'h0, 32'(loop_isolate));
      $display("test loss of lock done");
      activity_alarm <= 5'h02;
      want_lock <= 1'b0;
      wait_state(3'h5, 1000);
      chk("hold_time", 32'h1, 32'(n >= 760 && n <= 840));
      repeat (2) @(posedge clk);
      chk("src", 32'h2, 32'(integral_frequency_value_source));
      chk("ho_integral_frequency_value", 32'h123456, 32'(holdover_integral_frequency_value));
      activity_alarm <= 5'h00;
      wait_state(3'h2, 5);
      chk("state", 32'h2, 32'(loop_state_field));
      wait_state(3'h5, 2500);
      chk("to_time", 32'h1, 32'(n >= 1900 && n <= 2100));
      apb(0, 8'h20, 0, r, e);
      chk("lock_alarm", 32'h200, r);
      $display("test holdover done");
      apb(1, 8'h00, 32'h18, r, e);
      wait_state(3'h0, 5);
      chk("forced", 32'h0, 32'(loop_state_field));
      apb(1, 8'h00, 32'h10, r, e);
      apb(1, 8'h20, 32'h200, r, e);
      wait_state(3'h1, 5);
      chk("state", 32'h1, 32'(loop_state_field));
      $display("test force done");
      test_done;
   end
endmodule
